// *** gcir_top.v ***
// Host-facing control register bank of the graphics controller.
// Assumes synchronous inputs on core_clk_i; event inputs are one-cycle.
`include "gcir_defines.vh"

module gcir_top (
  input  wire        core_clk_i,
  input  wire        rst_i,
  input  wire [3:0]  addr_i,
  input  wire [15:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [15:0] rdata_o,
  input  wire [2:0]  clock_mode_pin_i,
  input  wire [6:0]  event_i,
  input  wire        vblank_i,
  input  wire        render_done_i,
  input  wire [15:0] pixel_i,
  output reg         clock_normal_o,
  output reg         command_enable_o,
  output reg         display_sync_run_o,
  output reg         sync_master_o,
  output reg  [15:0] display_data_out_o,
  output reg         render_busy_o,
  output reg         disp_buf_sel_o,
  output reg         dot_clk_en_o,
  output reg         interlace_o,
  output reg         colour_conv_en_o,
  output reg  [1:0]  row_address_sel_o,
  output reg  [2:0]  memory_size_sel_o,
  output reg  [3:0]  refresh_cycles_o,
  output reg         wide_space_o,
  output reg         depth16_o,
  output reg         yuv_conv_o,
  output reg         int_req_o
);

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  reg  [15:0] sys_reg;
  reg  [15:0] inten_reg;
  reg  [15:0] mem_reg;
  reg  [15:0] disp_reg;
  reg  [15:0] rend_reg;
  reg  [15:0] inconv_reg;
  reg  [6:0]  flag_reg;
  reg         swap_pend_reg;
  reg         buf_sel_reg;
  reg         div_reg;
  reg  [15:0] rdata_next;
  wire [6:0]  flag_next;

  wire [1:0] buffer_mode = sys_reg[`GCIR_SYS_BM_HI:`GCIR_SYS_BM_LO];

  function sel;
    input [3:0] a;
    input [3:0] b;
    begin
      sel = (a == b);
    end
  endfunction

  // --------------------------------------------------------------------
  // Write decode
  // --------------------------------------------------------------------
  wire wr_sys_w    = wr_i && sel(addr_i, `GCIR_ADDR_SYS);
  wire wr_stclr_w  = wr_i && sel(addr_i, `GCIR_ADDR_STCLR);
  wire wr_inten_w  = wr_i && sel(addr_i, `GCIR_ADDR_INTEN);
  wire wr_mem_w    = wr_i && sel(addr_i, `GCIR_ADDR_MEM);
  wire wr_disp_w   = wr_i && sel(addr_i, `GCIR_ADDR_DISP);
  wire wr_rend_w   = wr_i && sel(addr_i, `GCIR_ADDR_REND);
  wire wr_inconv_w = wr_i && sel(addr_i, `GCIR_ADDR_INCONV);

  // --------------------------------------------------------------------
  // Host write side
  // --------------------------------------------------------------------
  // Host write wins over the done pulse landing in the same cycle
  always @(posedge core_clk_i) begin
    if (rst_i)
      sys_reg <= `GCIR_SYS_RST;
    else if (wr_sys_w)
      sys_reg <= wdata_i & `GCIR_MASK_SYS;
    else if (render_done_i)
      sys_reg[`GCIR_SYS_RSTART] <= 1'b0;
  end

  always @(posedge core_clk_i) begin
    if (rst_i)
      inten_reg <= `GCIR_ZERO16;
    else if (wr_inten_w)
      inten_reg <= wdata_i & `GCIR_MASK_INTEN;
  end

  always @(posedge core_clk_i) begin
    if (rst_i)
      mem_reg <= `GCIR_ZERO16;
    else if (wr_mem_w)
      mem_reg <= wdata_i & `GCIR_MASK_MEM;
  end

  always @(posedge core_clk_i) begin
    if (rst_i)
      disp_reg <= `GCIR_ZERO16;
    else if (wr_disp_w)
      disp_reg <= wdata_i & `GCIR_MASK_DISP;
  end

  always @(posedge core_clk_i) begin
    if (rst_i)
      rend_reg <= `GCIR_ZERO16;
    else if (wr_rend_w)
      rend_reg <= wdata_i & `GCIR_MASK_REND;
  end

  always @(posedge core_clk_i) begin
    if (rst_i)
      inconv_reg <= `GCIR_ZERO16;
    else if (wr_inconv_w)
      inconv_reg <= wdata_i & `GCIR_MASK_INCONV;
  end

  // --------------------------------------------------------------------
  // Status flags
  // --------------------------------------------------------------------
  // Set beats clear so an event in the clearing cycle survives
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi = gi + 1) begin : g_flag
      assign flag_next[gi] = event_i[gi] || (flag_reg[gi] &&
        !(wr_stclr_w && wdata_i[`GCIR_INT_LO + gi]));
    end
  endgenerate

  always @(posedge core_clk_i) begin
    if (rst_i)
      flag_reg <= 7'h00;
    else
      flag_reg <= flag_next;
  end

  // --------------------------------------------------------------------
  // Frame buffer swap
  // --------------------------------------------------------------------
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      swap_pend_reg <= 1'b0;
      buf_sel_reg   <= 1'b0;
    end else begin
      if (vblank_i && (swap_pend_reg ||
          buffer_mode == `GCIR_BM_AUTO)) begin
        buf_sel_reg   <= ~buf_sel_reg;
        swap_pend_reg <= 1'b0;
      end
      if (wr_sys_w &&
          wdata_i[`GCIR_SYS_CHANGE] &&
          wdata_i[`GCIR_SYS_BM_HI:`GCIR_SYS_BM_LO] == `GCIR_BM_MANUAL)
        swap_pend_reg <= 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // Read port, one cycle later
  // --------------------------------------------------------------------
  always @* begin
    rdata_next = `GCIR_ZERO16;
    case (addr_i)
      `GCIR_ADDR_SYS:    rdata_next = sys_reg;
      `GCIR_ADDR_STATUS: rdata_next = {flag_reg, 8'h00, buf_sel_reg};
      `GCIR_ADDR_INTEN:  rdata_next = inten_reg;
      `GCIR_ADDR_MEM:    rdata_next = mem_reg;
      `GCIR_ADDR_DISP:   rdata_next = disp_reg;
      `GCIR_ADDR_REND:   rdata_next = rend_reg;
      `GCIR_ADDR_INCONV: rdata_next = inconv_reg;
      default:           rdata_next = `GCIR_ZERO16;
    endcase
  end

  // --------------------------------------------------------------------
  // Read data register
  // --------------------------------------------------------------------
  // Zero outside the read slot so a stale word never looks valid
  always @(posedge core_clk_i) begin
    if (rst_i)
      rdata_o <= `GCIR_ZERO16;
    else
      rdata_o <= rd_i ? rdata_next : `GCIR_ZERO16;
  end

  // --------------------------------------------------------------------
  // Clock mode and system control outputs
  // --------------------------------------------------------------------
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      clock_normal_o     <= 1'b0;
      command_enable_o   <= 1'b0;
      display_sync_run_o <= 1'b0;
      display_data_out_o <= `GCIR_ZERO16;
      render_busy_o      <= 1'b0;
    end else begin
      clock_normal_o <= (clock_mode_pin_i == `GCIR_CLK_MODE3);
      command_enable_o <= ~sys_reg[`GCIR_SYS_CMDRST];
      display_sync_run_o <= ~sys_reg[`GCIR_SYS_DISPRST];
      display_data_out_o <= sys_reg[`GCIR_SYS_DISPEN] ?
        pixel_i : `GCIR_ZERO16;
      render_busy_o <= sys_reg[`GCIR_SYS_RSTART] &&
        ~sys_reg[`GCIR_SYS_CMDRST];
    end
  end

  // --------------------------------------------------------------------
  // Displayed buffer
  // --------------------------------------------------------------------
  always @(posedge core_clk_i) begin
    if (rst_i)
      disp_buf_sel_o <= 1'b0;
    else
      disp_buf_sel_o <= buf_sel_reg;
  end

  // --------------------------------------------------------------------
  // Dot clock enable
  // --------------------------------------------------------------------
  // Divide by two gives a pulse every other cycle, else every cycle
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      div_reg      <= 1'b0;
      dot_clk_en_o <= 1'b0;
    end else begin
      div_reg      <= ~div_reg;
      dot_clk_en_o <= disp_reg[`GCIR_DISP_DOT] ? div_reg : 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // Display mode outputs
  // --------------------------------------------------------------------
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      sync_master_o    <= 1'b0;
      interlace_o      <= 1'b0;
      colour_conv_en_o <= 1'b0;
      refresh_cycles_o <= 4'h0;
    end else begin
      sync_master_o <= ~sys_reg[`GCIR_SYS_DISPRST] &&
        disp_reg[`GCIR_DISP_TVM_HI:`GCIR_DISP_TVM_LO] == 2'h0;
      interlace_o <= disp_reg[`GCIR_DISP_SCM_HI:`GCIR_DISP_SCM_LO] ==
        `GCIR_SCM_INTERLACE;
      colour_conv_en_o <= disp_reg[`GCIR_DISP_YCC];
      refresh_cycles_o <=
        disp_reg[`GCIR_DISP_REF_HI:`GCIR_DISP_REF_LO];
    end
  end

  // --------------------------------------------------------------------
  // Memory mode outputs
  // --------------------------------------------------------------------
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      row_address_sel_o <= 2'h0;
      memory_size_sel_o <= 3'h0;
    end else begin
      row_address_sel_o <=
        mem_reg[`GCIR_MEM_ROW_HI:`GCIR_MEM_ROW_LO];
      memory_size_sel_o <=
        mem_reg[`GCIR_MEM_SIZE_HI:`GCIR_MEM_SIZE_LO];
    end
  end

  // --------------------------------------------------------------------
  // Rendering and input conversion outputs
  // --------------------------------------------------------------------
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      wide_space_o <= 1'b0;
      depth16_o    <= 1'b0;
      yuv_conv_o   <= 1'b0;
    end else begin
      wide_space_o <= rend_reg[`GCIR_REND_WIDTH];
      depth16_o    <= rend_reg[`GCIR_REND_DEPTH];
      yuv_conv_o   <= inconv_reg[1:0] == `GCIR_INC_DYUV;
    end
  end

  // --------------------------------------------------------------------
  // Interrupt request
  // --------------------------------------------------------------------
  // Level request; it drops once software clears the flag or its enable bit
  always @(posedge core_clk_i) begin
    if (rst_i)
      int_req_o <= 1'b0;
    else
      int_req_o <= |(flag_reg & inten_reg[15:`GCIR_INT_LO]);
  end

endmodule

// *** gcir_defines.vh ***
// Constants for the graphics controller interface register bank.
// Assumes a host port of 4-bit word address and 16-bit data.
`ifndef GCIR_DEFINES_VH
`define GCIR_DEFINES_VH

// ----------------------------------------------------------------------
// Register word addresses
// ----------------------------------------------------------------------
`define GCIR_ADDR_SYS       4'h0
`define GCIR_ADDR_STATUS    4'h1
`define GCIR_ADDR_STCLR     4'h2
`define GCIR_ADDR_INTEN     4'h3
`define GCIR_ADDR_MEM       4'h4
`define GCIR_ADDR_DISP      4'h5
`define GCIR_ADDR_REND      4'h6
`define GCIR_ADDR_INCONV    4'h7

// ----------------------------------------------------------------------
// Writable bit masks
// ----------------------------------------------------------------------
`define GCIR_MASK_SYS       16'hE3FF
`define GCIR_MASK_INTEN     16'hFE00
`define GCIR_MASK_MEM       16'h007C
`define GCIR_MASK_DISP      16'h03FF
`define GCIR_MASK_REND      16'h0041
`define GCIR_MASK_INCONV    16'h0003
`define GCIR_MASK_STATUS    16'h00FE

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define GCIR_SYS_CMDRST     15
`define GCIR_SYS_DISPRST    14
`define GCIR_SYS_DISPEN     13
`define GCIR_SYS_CHANGE     9
`define GCIR_SYS_RSTART     8
`define GCIR_SYS_BM_HI      7
`define GCIR_SYS_BM_LO      6
`define GCIR_MEM_SIZE_HI    6
`define GCIR_MEM_SIZE_LO    4
`define GCIR_MEM_ROW_HI     3
`define GCIR_MEM_ROW_LO     2
`define GCIR_DISP_YCC       9
`define GCIR_DISP_DOT       8
`define GCIR_DISP_TVM_HI    7
`define GCIR_DISP_TVM_LO    6
`define GCIR_DISP_SCM_HI    5
`define GCIR_DISP_SCM_LO    4
`define GCIR_DISP_REF_HI    3
`define GCIR_DISP_REF_LO    0
`define GCIR_REND_WIDTH     6
`define GCIR_REND_DEPTH     0
`define GCIR_INT_LO         9
`define GCIR_ST_BUFSEL      0

// ----------------------------------------------------------------------
// Encodings and reset values
// ----------------------------------------------------------------------
`define GCIR_BM_AUTO        2'h1
`define GCIR_BM_MANUAL      2'h2
`define GCIR_SCM_INTERLACE  2'h2
`define GCIR_INC_DYUV       2'h2
`define GCIR_CLK_MODE3      3'h3
`define GCIR_SYS_RST        16'hC000
`define GCIR_ZERO16         16'h0000
`endif

// *** gcir_props.sv ***
// Port assertions for the control register bank.
// Assumes one clock domain and synchronous active-high reset.
module gcir_props (
  input wire        core_clk_i,
  input wire        rst_i,
  input wire [3:0]  addr_i,
  input wire [15:0] wdata_i,
  input wire        wr_i,
  input wire        rd_i,
  input wire [15:0] rdata_o,
  input wire [2:0]  clock_mode_pin_i,
  input wire        vblank_i,
  input wire [15:0] pixel_i,
  input wire        clock_normal_o,
  input wire        command_enable_o,
  input wire        display_sync_run_o,
  input wire        sync_master_o,
  input wire [15:0] display_data_out_o,
  input wire        render_busy_o,
  input wire        disp_buf_sel_o,
  input wire [2:0]  memory_size_sel_o,
  input wire [1:0]  row_address_sel_o,
  input wire [3:0]  refresh_cycles_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------
  // Properties
  // ------------------------------------------------
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  clk_norm_a: assert property (!$past(rst_i) |->
    clock_normal_o == ($past(clock_mode_pin_i) == 3'h3))
    else $error("clock mode decode wrong");
  pix_pass_a: assert property (display_data_out_o != 16'h0 |->
    display_data_out_o == $past(pixel_i))
    else $error("display data not from pixel input");
  rd_idle_a: assert property (!$past(rd_i) |-> rdata_o == 16'h0)
    else $error("read data outside read slot");
  unmap_rd_a: assert property ($past(rd_i) && $past(addr_i) > 4'h7
    |-> rdata_o == 16'h0)
    else $error("unmapped read not zero");
  mem_cfg_a: assert property (wr_i && addr_i == 4'h4 ##1
    !(wr_i && addr_i == 4'h4) |-> ##1
    {memory_size_sel_o, row_address_sel_o} == $past(wdata_i[6:2], 2))
    else $error("memory mode outputs wrong");
  refresh_a: assert property (wr_i && addr_i == 4'h5 ##1
    !(wr_i && addr_i == 4'h5) |-> ##1
    refresh_cycles_o == $past(wdata_i[3:0], 2))
    else $error("refresh timing output wrong");
  busy_cmd_a: assert property (render_busy_o |-> command_enable_o)
    else $error("rendering while commands held");
  sync_run_a: assert property (sync_master_o |-> display_sync_run_o)
    else $error("sync master while display held");
  swap_vbl_a: assert property ($changed(disp_buf_sel_o) |->
    $past(vblank_i, 2))
    else $error("buffer swap away from blanking");
  cover property (vblank_i ##2 $changed(disp_buf_sel_o));
  cover property (wr_i && addr_i == 4'h4);
  cover property ($past(rd_i) && rdata_o != 16'h0);
endmodule

bind gcir_top gcir_props u_props (.core_clk_i, .rst_i, .addr_i, .wdata_i,
  .wr_i, .rd_i, .rdata_o, .clock_mode_pin_i, .vblank_i, .pixel_i,
  .clock_normal_o, .command_enable_o, .display_sync_run_o, .sync_master_o,
  .display_data_out_o, .render_busy_o, .disp_buf_sel_o,
  .memory_size_sel_o, .row_address_sel_o, .refresh_cycles_o);

// *** gcir_host.sv ***
// Host processor model driving the register port.
// Assumes read data stand only in the cycle after the read strobe.
module gcir_host (
  input  wire         clk_i,
  input  wire  [15:0] rdata_i,
  output logic [3:0]  addr_o,
  output logic [15:0] wdata_o,
  output logic        wr_o,
  output logic        rd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------
  // Bus cycles
  // ------------------------------------------------
  initial begin
    addr_o = 4'h0;
    wdata_o = 16'h0;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // Released lines flip so stale values never look valid
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    @(negedge clk_i);
    d = rdata_i;
  endtask
endmodule

// *** tb_gcir_top.sv ***
// Self-checking bench for the control register bank.
// Assumes gcir_host as bus master and gcir_props bound to the top.
`include "gcir_defines.vh"
`define CHK(n, e, v) begin comparisons++; if ((v) !== (e)) begin \
  err_total++; $display("Error %s exp %h got %h", n, e, v); end end
module tb_gcir_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, vb = 0, done = 0;
  logic [2:0] pins = 3'h3;
  logic [6:0] ev = 7'h0;
  logic [15:0] pix = 16'h0, rdat, q;
  wire [3:0] a;
  wire [15:0] wd;
  wire w, r, cn, ce, sr, sm, bs, dc, il, cc, ws, d16, yc, irq, busy;
  wire [15:0] dd;
  wire [1:0] ra;
  wire [2:0] ms;
  wire [3:0] rf;
  int err_total = 0, comparisons = 0, cyc = 0;
  // Address, write data, expected read-back
  localparam logic [35:0] ROWS [10] = '{36'h3FFFFFE00, 36'h4FFFF007C,
    36'h400240024, 36'h501250125, 36'h6FFFF0041, 36'h700020002,
    36'h2FFFF0000, 36'h1FFFF0000, 36'h912340000, 36'hFFFFF0000};
  gcir_host host (.clk_i(clk), .rdata_i(rdat), .addr_o(a), .wdata_o(wd),
    .wr_o(w), .rd_o(r));
  gcir_top dut (.core_clk_i(clk), .rst_i(rst), .addr_i(a), .wdata_i(wd),
    .wr_i(w), .rd_i(r), .rdata_o(rdat), .clock_mode_pin_i(pins),
    .event_i(ev), .vblank_i(vb), .render_done_i(done), .pixel_i(pix),
    .clock_normal_o(cn), .command_enable_o(ce), .display_sync_run_o(sr),
    .sync_master_o(sm), .display_data_out_o(dd), .render_busy_o(busy),
    .disp_buf_sel_o(bs), .dot_clk_en_o(dc), .interlace_o(il),
    .colour_conv_en_o(cc), .row_address_sel_o(ra),
    .memory_size_sel_o(ms), .refresh_cycles_o(rf), .wide_space_o(ws),
    .depth16_o(d16), .yuv_conv_o(yc), .int_req_o(irq));
  // ------------------------------------------------
  // Clock, pixels, timeout
  // ------------------------------------------------
  initial begin
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    pix <= pix + 16'h1357;
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      stop_test();
    end
  end
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    host.rd(`GCIR_ADDR_SYS, q);
    `CHK("sys reset", `GCIR_SYS_RST, q)
    `CHK("cmd held", 1'b0, ce)
    `CHK("clk normal", 1'b1, cn)
    @(posedge clk) pins <= 3'h7;
    settle();
    `CHK("clk other", 1'b0, cn)
    foreach (ROWS[i]) begin
      host.wr(ROWS[i][35:32], ROWS[i][31:16]);
      host.rd(ROWS[i][35:32], q);
      `CHK("readback", ROWS[i][15:0], q)
    end
    `CHK("mem size", 3'h2, ms)
    `CHK("row bits", 2'h1, ra)
    `CHK("refresh", 4'h5, rf)
    `CHK("interlace", 1'b1, il)
    `CHK("ycc off", 1'b0, cc)
    `CHK("width", 1'b1, ws)
    `CHK("depth", 1'b1, d16)
    `CHK("yuv", 1'b1, yc)
    q[0] = dc;
    #25;
    `CHK("dot half", ~q[0], dc)
    host.wr(`GCIR_ADDR_SYS, 16'h2000);
    settle();
    `CHK("cmd run", 1'b1, ce)
    `CHK("sync run", 1'b1, sr)
    `CHK("master", 1'b1, sm)
    `CHK("pixels out", 1'b1, |dd)
    @(posedge clk) ev <= 7'h04;
    @(posedge clk) ev <= 7'h00;
    settle();
    `CHK("irq on", 1'b1, irq)
    host.rd(`GCIR_ADDR_STATUS, q);
    `CHK("status", 16'h0800, q)
    host.wr(`GCIR_ADDR_STCLR, 16'h0000);
    settle();
    `CHK("irq kept", 1'b1, irq)
    host.wr(`GCIR_ADDR_STCLR, 16'h0800);
    settle();
    `CHK("irq clear", 1'b0, irq)
    host.wr(`GCIR_ADDR_INTEN, 16'h0000);
    @(posedge clk) ev <= 7'h04;
    @(posedge clk) ev <= 7'h00;
    settle();
    `CHK("irq masked", 1'b0, irq)
    host.wr(`GCIR_ADDR_SYS, 16'h2280);
    settle();
    `CHK("no early swap", 1'b0, bs)
    @(posedge clk) vb <= 1'b1;
    @(posedge clk) vb <= 1'b0;
    settle();
    `CHK("swapped", 1'b1, bs)
    host.wr(`GCIR_ADDR_SYS, 16'h2100);
    settle();
    `CHK("render on", 1'b1, busy)
    @(posedge clk) done <= 1'b1;
    @(posedge clk) done <= 1'b0;
    settle();
    `CHK("render off", 1'b0, busy)
    host.wr(`GCIR_ADDR_DISP, 16'h0200);
    settle();
    `CHK("ycc on", 1'b1, cc)
    // Second reset in mid-run, with the buffer swapped and conversion on
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    host.rd(`GCIR_ADDR_SYS, q);
    `CHK("sys re-reset", `GCIR_SYS_RST, q)
    `CHK("sync held", 1'b0, sr)
    `CHK("ycc reset", 1'b0, cc)
    `CHK("buf reset", 1'b0, bs)
    stop_test();
  end
endmodule
